// ### verilog/wwdt_consts.vh
// Purpose: shared constants for the watchdog block
// Assumes: APB, 32-bit data, two register words
// Notes: header holds definitions only
`ifndef WWDT_CONSTS_VH
`define WWDT_CONSTS_VH
// ==========================================================
// Register map
`define WWDT_ADDR_W 4
`define WWDT_OFF_CTRL 4'h0
`define WWDT_OFF_MODE 4'h4
`define WWDT_CTRL_RESET 8'h7F
`define WWDT_BIT_EN 7
`define WWDT_BIT_MSB 6
`define WWDT_CNT_MAX 7'h7F
`define WWDT_CNT_TRIP 7'h40
// ==========================================================
// Mode register fields
`define WWDT_MODE_DLYSEL 0
// ==========================================================
// Timing
`define WWDT_PRESCALE 16384
`define WWDT_DLY_SHORT 256
`define WWDT_DLY_LONG 4096
`define WWDT_PRE_W 14
`define WWDT_DLY_W 13
`define WWDT_OPT_WAIT 3'h5
`endif

// ### verilog/wwdt_sync.v
// Purpose: three-stage synchroniser with agreement filter
// Assumes: input is asynchronous to pclk
// Notes: first stage is read only by the second
`timescale 1ns/1ps
`include "wwdt_consts.vh"
module wwdt_sync #(
  parameter WIDTH = 1
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Data
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;
  reg [WIDTH-1:0] stage3;
  integer i;
  // ==========================================================
  // Capture, then accept a bit once stages two and three agree
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1 <= {WIDTH{1'b0}};
      stage2 <= {WIDTH{1'b0}};
      stage3 <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
      for (i = 0; i < WIDTH; i = i + 1) begin
        if (stage2[i] == stage3[i]) begin
          sync_out[i] <= stage3[i];
        end
      end
    end
  end
endmodule // wwdt_sync

// ### verilog/wwdt_core.v
// Purpose: 7-bit watchdog down-counter with APB control register
// Assumes: pclk is both oscillator and CPU clock; low-power status from the system
// Notes: halt, wake and option inputs are asynchronous pins, synchronised here
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "wwdt_consts.vh"
// Contract
// - The counter lives in control bits 6:0 and steps down once per 16384 oscillator cycles.
// - While enabled, a reset is raised when the counter falls from 40h to 3Fh.
// - The enable bit is set only by software and cleared only by reset, and gates the counter-trip reset only, not the halt reset.
// - After reset the control register reads 7Fh.
// - With the hardware-watchdog option the watchdog is always active regardless of enable.
// - Slow and wait modes leave the watchdog running unchanged.
// - In plain halt the counter steps once and then stops, with no reset, until a wake-up.
// - An external interrupt ending plain halt restarts counting after 256 or 4096 clocks.
// - A reset ending plain halt returns the watchdog to its disabled state unless hardware mode.
// - Halt with the clock interrupt off and the halt-reset option on raises a reset.
// - Halt with the clock interrupt enabled enters active halt instead.
// - Active halt neither decrements nor resets, whatever the halt-reset option.
// - Waking from active halt by an interrupt resumes counting at once.
// - A reset ending active halt restarts counting after 256 or 4096 clocks; here always 256, as reset clears the delay select.
module wwdt_core #(
  parameter PRESCALE = `WWDT_PRESCALE,
  parameter DLY_SHORT = `WWDT_DLY_SHORT,
  parameter DLY_LONG = `WWDT_DLY_LONG
) (
  // APB
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  // System status, asynchronous pins
  input wire halt_req,
  input wire ext_wake,
  input wire osc_wake,
  input wire rtc_interrupt_enable,
  input wire halt_reset_option,
  input wire hw_watchdog_option,
  // Reset request and state
  output reg wdg_reset,
  output wire wdg_active,
  output wire [1:0] wdg_halt_state
);
  localparam ST_RUN = 4'b0001;
  localparam ST_HALT = 4'b0010;
  localparam ST_AHALT = 4'b0100;
  localparam ST_DELAY = 4'b1000;
  reg [3:0] state;
  reg [3:0] next_state;
  reg dog_activation;
  reg [6:0] cnt;
  reg [`WWDT_PRE_W-1:0] pre;
  reg [`WWDT_DLY_W-1:0] dly;
  reg halted_once;
  reg dly_long_sel;
  reg hw_opt;
  reg [2:0] opt_wait;
  reg next_activation;
  reg [6:0] next_cnt;
  reg next_wdg_reset;
  reg [31:0] next_prdata;
  reg [`WWDT_DLY_W-1:0] next_dly;
  reg [1:0] halt_flags;
  reg halt_d;
  reg restart_delay;
  wire [5:0] sync_raw;
  wire [5:0] sync_val;
  wire s_halt;
  wire s_ext;
  wire s_osc;
  wire s_rtc;
  wire s_hro;
  wire s_hw;
  wire halt_rise;
  wire tick;
  wire counting;
  wire armed;
  wire wr;
  wire rd;
  wire sel_ctrl;
  wire sel_mode;
  wire [`WWDT_DLY_W-1:0] dly_load;
  wire [31:0] ctrl_word;
  wire trip;
  wire halt_forbid;
  wire wake_plain;
  wire wake_active;
  wire ctrl_write;
  wire mode_write;
  wire [3:0] state_in;
  // ==========================================================
  // Pin synchronisers
  // The option strap shares the filter, so it settles a few edges after reset release
  assign sync_raw = {hw_watchdog_option, halt_reset_option, rtc_interrupt_enable,
                     osc_wake, ext_wake, halt_req};
  wwdt_sync #(.WIDTH(6)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(sync_raw),
    .sync_out(sync_val)
  );
  assign {s_hw, s_hro, s_rtc, s_osc, s_ext, s_halt} = sync_val;
  // ==========================================================
  // APB decode
  // Zero wait states: each access ends in its first access cycle
  assign pready = 1'b1;
  assign sel_ctrl = paddr[`WWDT_ADDR_W-1:0] == `WWDT_OFF_CTRL;
  assign sel_mode = paddr[`WWDT_ADDR_W-1:0] == `WWDT_OFF_MODE;
  assign pslverr = psel & penable & ~(sel_ctrl | sel_mode);
  assign wr = psel & penable & pwrite & ~pslverr;
  assign rd = psel & ~penable & ~pwrite;
  assign ctrl_word = {24'h000000, dog_activation, cnt};
  assign ctrl_write = wr & sel_ctrl;
  assign mode_write = wr & sel_mode;
  // Read word is chosen in the setup phase so that it stands for the whole access phase
  always @* begin
    next_prdata = prdata;
    if (rd) begin
      if (sel_ctrl) begin
        next_prdata = ctrl_word;
      end else if (sel_mode) begin
        next_prdata = {31'h0, dly_long_sel};
      end else begin
        next_prdata = 32'h00000000;
      end
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else begin
      prdata <= next_prdata;
    end
  end
  // ==========================================================
  // Hardware option strap, caught once the synchroniser has settled after reset release
  // At the first edge the synchroniser still shows its reset value, not the strap
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hw_opt <= 1'b0;
      opt_wait <= 3'h0;
    end else if (opt_wait != `WWDT_OPT_WAIT) begin
      hw_opt <= s_hw;
      opt_wait <= opt_wait + 3'h1;
    end
  end
  assign armed = dog_activation | hw_opt;
  assign wdg_active = armed;
  // ==========================================================
  // Low-power state machine
  assign halt_rise = s_halt & ~halt_d;
  // Only an external interrupt ends plain halt; the clock interrupt also ends active halt
  assign wake_plain = s_ext;
  assign wake_active = s_ext | s_osc;
  assign dly_load = dly_long_sel ? DLY_LONG[`WWDT_DLY_W-1:0] - 1'b1
                                 : DLY_SHORT[`WWDT_DLY_W-1:0] - 1'b1;
  always @* begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (halt_rise && s_rtc) begin
          next_state = ST_AHALT;
        end else if (halt_rise && !s_hro) begin
          next_state = ST_HALT;
        end
      end
      ST_HALT: begin
        if (wake_plain) begin
          next_state = ST_DELAY;
        end
      end
      ST_AHALT: begin
        if (wake_active) begin
          next_state = ST_RUN;
        end
      end
      ST_DELAY: begin
        if (dly == {`WWDT_DLY_W{1'b0}}) begin
          next_state = ST_RUN;
        end
      end
      default: begin
        next_state = ST_RUN;
      end
    endcase
  end
  assign state_in = restart_delay ? ST_DELAY : next_state;
  always @* begin
    next_dly = dly;
    if (restart_delay || (state == ST_HALT && next_state == ST_DELAY)) begin
      next_dly = dly_load;
    end else if (state == ST_DELAY && dly != {`WWDT_DLY_W{1'b0}}) begin
      next_dly = dly - 1'b1;
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_RUN;
      halt_flags <= 2'b00;
      halt_d <= 1'b0;
      dly <= {`WWDT_DLY_W{1'b0}};
      restart_delay <= 1'b1;
    end else begin
      halt_d <= s_halt;
      state <= state_in;
      halt_flags <= {state_in == ST_AHALT, state_in == ST_HALT};
      dly <= next_dly;
      restart_delay <= 1'b0;
    end
  end
  // ==========================================================
  // Status outputs
  // Halt flags are registered from the state's next value, so they always match the state
  assign wdg_halt_state = halt_flags;
  // ==========================================================
  // Prescaler and counter
  // Plain halt lets exactly one prescaled step through before the counter freezes
  // The prescaler keeps its phase while frozen instead of restarting the period
  // slow and wait ignored
  assign counting = (state == ST_RUN) || (state == ST_HALT && !halted_once);
  assign tick = counting && (pre == PRESCALE[`WWDT_PRE_W-1:0] - 1'b1);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre <= {`WWDT_PRE_W{1'b0}};
      halted_once <= 1'b0;
    end else begin
      if (!counting) begin
        pre <= pre;
      end else if (tick) begin
        pre <= {`WWDT_PRE_W{1'b0}};
      end else begin
        pre <= pre + 1'b1;
      end
      if (state != ST_HALT) begin
        halted_once <= 1'b0;
      end else if (tick) begin
        halted_once <= 1'b1;
      end
    end
  end
  // write loads counter
  // A write and a tick in one cycle: the software reload wins
  always @* begin
    next_cnt = cnt;
    next_activation = dog_activation;
    if (ctrl_write) begin
      next_cnt = pwdata[`WWDT_BIT_MSB:0];
      if (pwdata[`WWDT_BIT_EN]) begin
        next_activation = 1'b1;
      end
    end else if (tick) begin
      next_cnt = cnt - 7'h01;
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dog_activation <= 1'b0;
      cnt <= `WWDT_CNT_MAX;
      dly_long_sel <= 1'b0;
    end else begin
      dog_activation <= next_activation;
      cnt <= next_cnt;
      if (mode_write) begin
        dly_long_sel <= pwdata[`WWDT_MODE_DLYSEL];
      end
    end
  end
  // ==========================================================
  // Reset request, held until system reset; no interrupt exists
  // trip at 40h to 3Fh
  assign trip = armed && tick && (cnt == `WWDT_CNT_TRIP) && (state != ST_HALT);
  assign halt_forbid = (state == ST_RUN) && halt_rise && !s_rtc && s_hro;
  always @* begin
    next_wdg_reset = wdg_reset;
    if (trip || halt_forbid) begin
      next_wdg_reset = 1'b1;
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdg_reset <= 1'b0;
    end else begin
      wdg_reset <= next_wdg_reset;
    end
  end
endmodule // wwdt_core

// ### testbench/wwdt_properties.sv
// Purpose: port assertions for the watchdog core
// Assumes: single clock, async active-low reset
// Notes: counter is seen only through reads
`timescale 1ns/1ps
// ==========================================================
// Checker
module wwdt_props (
  // Bus
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire pready,
  input wire [31:0] prdata,
  input wire pslverr,
  // Status
  input wire wdg_reset,
  input wire wdg_active,
  input wire [1:0] wdg_halt_state
);
  wire acc = psel && penable;
  wire bad = paddr[3:0] != 4'h0 && paddr[3:0] != 4'h4;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  zero_wait_a: assert property (acc |-> pready)
    else $error("pready low in access");
  slave_err_a: assert property (acc |-> pslverr == bad)
    else $error("slave error wrong");
  ctrl_upper_a: assert property (acc && !pwrite && !bad && !paddr[2] |-> !(|prdata[31:8]))
    else $error("upper read bits set");
  reset_level_a: assert property (wdg_reset |=> wdg_reset)
    else $error("reset request dropped");
  enable_sticky_a: assert property (wdg_active |=> wdg_active)
    else $error("watchdog disarmed");
  active_calm_a: assert property (wdg_halt_state[1] && !wdg_reset |=> !wdg_reset)
    else $error("reset in active halt");
  halt_calm_a: assert property (wdg_halt_state[0] && !wdg_reset |=> !wdg_reset)
    else $error("reset in plain halt");
  halt_kind_a: assert property (wdg_halt_state != 2'b11)
    else $error("both halt kinds");
  cover property ($rose(wdg_reset));
  cover property (wdg_halt_state[1]);
  cover property (wdg_halt_state[0]);
endmodule // wwdt_props

// ### testbench/tb.sv
// Purpose: self-checking bench for the watchdog core
// Assumes: short prescale and delays for run time
// Notes: halt and wake pins pass a synchroniser
`timescale 1ns/1ps
// ==========================================================
// Bench
module tb;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, rd;
  logic halt_req = 1'b0, ext_wake = 1'b0, osc_wake = 1'b0, rtc_interrupt_enable = 1'b0;
  logic halt_reset_option = 1'b0, hw_watchdog_option = 1'b0, er;
  wire pready, pslverr, wdg_reset, wdg_active;
  wire [31:0] prdata;
  wire [1:0] wdg_halt_state;
  int num_errors = 0, n_tests = 0;
  always #4 pclk = ~pclk;
  wwdt_core #(.PRESCALE(16), .DLY_SHORT(4), .DLY_LONG(8)) u_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .halt_req(halt_req),
    .ext_wake(ext_wake), .osc_wake(osc_wake), .rtc_interrupt_enable(rtc_interrupt_enable),
    .halt_reset_option(halt_reset_option), .hw_watchdog_option(hw_watchdog_option),
    .wdg_reset(wdg_reset), .wdg_active(wdg_active), .wdg_halt_state(wdg_halt_state));
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 8; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 8) begin
      num_errors++;
      final_report();
    end
  endtask
  task automatic wait_rst(input int lim, input logic exp);
    int i;
    for (i = 0; i < lim && wdg_reset !== 1'b1; i++) @(posedge pclk);
    chk("wdg_reset", exp, wdg_reset);
    if (exp && wdg_reset !== 1'b1) final_report();
  endtask
  task automatic do_reset(input logic hw);
    presetn <= 1'b0;
    hw_watchdog_option <= hw;
    {halt_req, ext_wake, osc_wake, rtc_interrupt_enable, halt_reset_option} <= 5'h00;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
  endtask
  // ==========================================================
  // Scenarios
  task automatic s_regs();
    do_reset(1'b0);
    apb(1'b0, 32'h0, 32'h0);
    chk("ctrl reset", 32'h7F, rd);
    apb(1'b0, 32'h8, 32'h0);
    chk("unmapped", 32'h1, {31'h0, er});
    apb(1'b1, 32'h0, 32'h41);
    wait_rst(200, 1'b0);
    apb(1'b0, 32'h0, 32'h0);
    chk("enable off", 32'h0, rd[7]);
  endtask
  task automatic s_trip();
    apb(1'b1, 32'h0, 32'hC4);
    wait_rst(60, 1'b0);
    wait_rst(30, 1'b1);
  endtask
  task automatic s_plain();
    do_reset(1'b0);
    apb(1'b1, 32'h4, 32'h1);
    apb(1'b1, 32'h0, 32'hC8);
    halt_req <= 1'b1;
    repeat (8) @(posedge pclk);
    chk("plain halt", 32'h1, wdg_halt_state);
    wait_rst(100, 1'b0);
    apb(1'b0, 32'h0, 32'h0);
    chk("halt count", 32'h1, rd[6:0] == 7'h47 || rd[6:0] == 7'h46);
    ext_wake <= 1'b1;
    repeat (8) @(posedge pclk);
    chk("woken", 32'h0, wdg_halt_state);
    wait_rst(150, 1'b1);
  endtask
  task automatic s_active();
    logic [31:0] held;
    do_reset(1'b0);
    chk("disabled", 32'h0, wdg_active);
    rtc_interrupt_enable <= 1'b1;
    halt_reset_option <= 1'b1;
    apb(1'b1, 32'h0, 32'hC4);
    halt_req <= 1'b1;
    repeat (8) @(posedge pclk);
    chk("active halt", 32'h2, wdg_halt_state);
    apb(1'b0, 32'h0, 32'h0);
    held = rd;
    wait_rst(100, 1'b0);
    apb(1'b0, 32'h0, 32'h0);
    chk("frozen", held, rd);
    osc_wake <= 1'b1;
    wait_rst(100, 1'b1);
  endtask
  task automatic s_opts();
    do_reset(1'b0);
    halt_reset_option <= 1'b1;
    halt_req <= 1'b1;
    wait_rst(12, 1'b1);
    do_reset(1'b1);
    chk("hw active", 32'h1, wdg_active);
    apb(1'b1, 32'h0, 32'h44);
    wait_rst(100, 1'b1);
  endtask
  initial begin
    s_regs();
    s_trip();
    s_plain();
    s_active();
    s_opts();
    final_report();
  end
endmodule // tb
bind wwdt_core wwdt_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .wdg_reset(wdg_reset), .wdg_active(wdg_active),
  .wdg_halt_state(wdg_halt_state));
